// ==== design/dps_flash_map.svh ====
// constants for the dual plane flash host sequencer: addresses, command data, timing
// assumes a 100 MHz clock and a word wide (x16) flash bus
`ifndef DPS_FLASH_MAP_SVH
`define DPS_FLASH_MAP_SVH

`define DPS_CLK_MHZ 100
`define DPS_CYC(ns) (((ns) * `DPS_CLK_MHZ + 999) / 1000)

// bus timing in ns, least times rounded up to cycles; erase limit in seconds
`define DPS_WP_NS 100
`define DPS_WR_GAP_NS 150
`define DPS_RD_ACC_NS 120
`define DPS_RD_GAP_NS 150
`define DPS_ERASE_MAX_S 10

// unlock addresses and command data
`define DPS_UNLOCK_A1 19'h05555
`define DPS_UNLOCK_A2 19'h02aaa
`define DPS_D_AA 16'h00aa
`define DPS_D_55 16'h0055
`define DPS_D_80 16'h0080
`define DPS_D_CHIP 16'h0010
`define DPS_D_SECTOR 16'h0030
`define DPS_D_ID_EXIT 16'h00f0

// command lengths in bus cycles, minus one
`define DPS_LAST_ERASE 3'h5
`define DPS_LAST_ID_LONG 3'h2
`define DPS_LAST_ID_SHORT 3'h0

// status bit positions
`define DPS_TOGGLE_BIT 6

`endif

// ==== design/dps_pkg.sv ====
// types for the dual plane flash host sequencer
// shared by the design and the bench
package dps_pkg;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_WR_SET  = 3'b001,
        ST_WR_LOW  = 3'b010,
        ST_WR_HIGH = 3'b011,
        ST_RD_LOW  = 3'b100,
        ST_RD_HIGH = 3'b101
    } dps_state_t;

    typedef enum logic [2:0] {
        OP_READ         = 3'b000,
        OP_CHIP_ERASE   = 3'b001,
        OP_SECTOR_ERASE = 3'b010,
        OP_ID_EXIT_LONG = 3'b011,
        OP_ID_EXIT_SHORT = 3'b100
    } dps_op_t;

    typedef struct packed {
        dps_op_t op;
        logic [18:0] addr;
    } dps_req_t;

    typedef struct packed {
        logic [18:0] addr;
        logic ceN;
        logic oeN;
        logic weN;
        logic [15:0] dqOut;
        logic dqOe;
    } dps_pins_t;

endpackage

// ==== design/dps_flash_host.sv ====
// host sequencer that drives a dual plane parallel flash over its strobes
// assumes flash data pins are sampled synchronously to clk; dqOe high drives the bus
//
// What this block does
// - the last erase cycle writes 10h to 5555h for chip erase or 30h into the sector.
// - write enable stays high at least 150 ns between the fifth and sixth erase cycles.
// - output enable is held high whenever write enable and chip select are both low.
// - every poll read checks the toggle bit, and the read strobe stays high 150 ns between reads.
// - toggle polling keeps one address for all status reads, the erase request address.
`timescale 1ns/1ns
`include "dps_flash_map.svh"

module dps_flash_host
    import dps_pkg::*;
#(
    parameter logic [31:0] ERASE_TIMEOUT_CYC = `DPS_ERASE_MAX_S * 1000000 * `DPS_CLK_MHZ
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic reqValid,
    input wire dps_req_t req,
    output logic reqReady,
    output logic rspDone,
    output logic [15:0] rspData,
    output logic rspTimeout,
    output dps_pins_t pins,
    input wire logic [15:0] dqIn
);

    localparam logic [7:0] WP_CYC = 8'(`DPS_CYC(`DPS_WP_NS));
    localparam logic [7:0] WR_GAP_CYC = 8'(`DPS_CYC(`DPS_WR_GAP_NS));
    localparam logic [7:0] RD_CYC = 8'(`DPS_CYC(`DPS_RD_ACC_NS));
    localparam logic [7:0] RD_GAP_CYC = 8'(`DPS_CYC(`DPS_RD_GAP_NS));

    dps_state_t stateReg, stateNext;
    dps_op_t opReg, opNext;
    logic [2:0] stepReg, stepNext;
    logic [7:0] cntReg, cntNext;
    logic [31:0] tmoReg, tmoNext;
    logic [18:0] sectReg, sectNext;
    logic pollReg, pollNext;
    logic havePrevReg, havePrevNext;
    logic prevTogReg, prevTogNext;
    logic finishReg, finishNext;
    dps_pins_t pinsReg, pinsNext;
    logic readyReg, readyNext;
    logic doneReg, doneNext;
    logic [15:0] dataReg, dataNext;
    logic timeoutReg, timeoutNext;

    // last bus cycle index of each command
    function automatic logic [2:0] lastStep(input dps_op_t op);
        case (op)
            OP_CHIP_ERASE, OP_SECTOR_ERASE: lastStep = `DPS_LAST_ERASE;
            OP_ID_EXIT_LONG: lastStep = `DPS_LAST_ID_LONG;
            default: lastStep = `DPS_LAST_ID_SHORT;
        endcase
    endfunction

    // address of each command bus cycle
    function automatic logic [18:0] cmdAddr(input dps_op_t op, input logic [2:0] step,
                                            input logic [18:0] sect);
        if (op == OP_ID_EXIT_SHORT) begin
            cmdAddr = `DPS_UNLOCK_A1;
        end else if (step == 3'h1 || step == 3'h4) begin
            cmdAddr = `DPS_UNLOCK_A2;
        end else if (step == `DPS_LAST_ERASE && op == OP_SECTOR_ERASE) begin
            cmdAddr = sect;
        end else begin
            cmdAddr = `DPS_UNLOCK_A1;
        end
    endfunction

    // data of each command bus cycle
    function automatic logic [15:0] cmdData(input dps_op_t op, input logic [2:0] step);
        if (op == OP_ID_EXIT_SHORT || (op == OP_ID_EXIT_LONG && step == `DPS_LAST_ID_LONG)) begin
            cmdData = `DPS_D_ID_EXIT;
        end else begin
            case (step)
                3'h0, 3'h3: cmdData = `DPS_D_AA;
                3'h1, 3'h4: cmdData = `DPS_D_55;
                3'h2: cmdData = `DPS_D_80;
                default: cmdData = (op == OP_CHIP_ERASE) ? `DPS_D_CHIP : `DPS_D_SECTOR;
            endcase
        end
    endfunction

    // sequencer next state
    always_comb begin
        stateNext = stateReg;
        opNext = opReg;
        stepNext = stepReg;
        cntNext = cntReg;
        tmoNext = tmoReg;
        sectNext = sectReg;
        pollNext = pollReg;
        havePrevNext = havePrevReg;
        prevTogNext = prevTogReg;
        finishNext = finishReg;
        readyNext = readyReg;
        doneNext = 1'b0;
        dataNext = dataReg;
        timeoutNext = timeoutReg;
        if (pollReg) begin
            tmoNext = tmoReg + 32'h1;
        end
        case (stateReg)
            ST_IDLE: begin
                if (reqValid && readyReg) begin
                    opNext = req.op;
                    sectNext = req.addr;
                    stepNext = 3'h0;
                    readyNext = 1'b0;
                    timeoutNext = 1'b0;
                    finishNext = 1'b0;
                    pollNext = 1'b0;
                    if (req.op == OP_READ) begin
                        stateNext = ST_RD_LOW;
                        cntNext = RD_CYC - 8'h1;
                    end else begin
                        stateNext = ST_WR_SET;
                    end
                end
            end
            ST_WR_SET: begin
                stateNext = ST_WR_LOW;
                cntNext = WP_CYC - 8'h1;
            end
            ST_WR_LOW: begin
                if (cntReg == 8'h0) begin
                    stateNext = ST_WR_HIGH;
                    cntNext = WR_GAP_CYC - 8'h1;
                end else begin
                    cntNext = cntReg - 8'h1;
                end
            end
            ST_WR_HIGH: begin
                if (cntReg != 8'h0) begin
                    cntNext = cntReg - 8'h1;
                end else if (stepReg != lastStep(opReg)) begin
                    stepNext = stepReg + 3'h1;
                    stateNext = ST_WR_SET;
                end else if (opReg == OP_CHIP_ERASE || opReg == OP_SECTOR_ERASE) begin
                    // erase launched: poll the toggle bit until it stands still
                    stateNext = ST_RD_LOW;
                    cntNext = RD_CYC - 8'h1;
                    pollNext = 1'b1;
                    havePrevNext = 1'b0;
                    tmoNext = 32'h0;
                end else begin
                    stateNext = ST_IDLE;
                    doneNext = 1'b1;
                    readyNext = 1'b1;
                end
            end
            ST_RD_LOW: begin
                if (cntReg != 8'h0) begin
                    cntNext = cntReg - 8'h1;
                end else begin
                    stateNext = ST_RD_HIGH;
                    cntNext = RD_GAP_CYC - 8'h1;
                    dataNext = dqIn;
                    prevTogNext = dqIn[`DPS_TOGGLE_BIT];
                    havePrevNext = 1'b1;
                    if (!pollReg || (havePrevReg && dqIn[`DPS_TOGGLE_BIT] == prevTogReg)) begin
                        finishNext = 1'b1;
                        pollNext = 1'b0;
                    end
                end
            end
            ST_RD_HIGH: begin
                if (pollReg && tmoReg >= ERASE_TIMEOUT_CYC) begin
                    finishNext = 1'b1;
                    timeoutNext = 1'b1;
                    pollNext = 1'b0;
                end
                if (cntReg != 8'h0) begin
                    cntNext = cntReg - 8'h1;
                end else if (finishReg) begin
                    stateNext = ST_IDLE;
                    doneNext = 1'b1;
                    readyNext = 1'b1;
                end else if (!finishNext) begin
                    stateNext = ST_RD_LOW;
                    cntNext = RD_CYC - 8'h1;
                end
            end
            default: begin
                stateNext = ST_IDLE;
                readyNext = 1'b1;
            end
        endcase
    end

    // pin values follow the next state so every pin is a flop
    always_comb begin
        pinsNext = pinsReg;
        pinsNext.ceN = !(stateNext == ST_WR_SET || stateNext == ST_WR_LOW
                         || stateNext == ST_RD_LOW);
        pinsNext.weN = !(stateNext == ST_WR_LOW);
        pinsNext.oeN = !(stateNext == ST_RD_LOW);
        pinsNext.dqOe = (stateNext == ST_WR_SET) || (stateNext == ST_WR_LOW)
                        || (stateNext == ST_WR_HIGH && stateReg == ST_WR_LOW);
        if (stateNext == ST_WR_SET) begin
            pinsNext.addr = cmdAddr(opNext, stepNext, sectNext);
            pinsNext.dqOut = cmdData(opNext, stepNext);
        end else if (stateNext == ST_RD_LOW) begin
            pinsNext.addr = sectNext;
        end
    end

    // state registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stateReg <= ST_IDLE;
            opReg <= OP_READ;
            stepReg <= 3'h0;
            cntReg <= 8'h0;
            tmoReg <= 32'h0;
            sectReg <= 19'h0;
            pollReg <= 1'b0;
            havePrevReg <= 1'b0;
            prevTogReg <= 1'b0;
            finishReg <= 1'b0;
            pinsReg <= '{addr: 19'h0, ceN: 1'b1, oeN: 1'b1, weN: 1'b1, dqOut: 16'h0,
                         dqOe: 1'b0};
            readyReg <= 1'b1;
            doneReg <= 1'b0;
            dataReg <= 16'h0;
            timeoutReg <= 1'b0;
        end else begin
            stateReg <= stateNext;
            opReg <= opNext;
            stepReg <= stepNext;
            cntReg <= cntNext;
            tmoReg <= tmoNext;
            sectReg <= sectNext;
            pollReg <= pollNext;
            havePrevReg <= havePrevNext;
            prevTogReg <= prevTogNext;
            finishReg <= finishNext;
            pinsReg <= pinsNext;
            readyReg <= readyNext;
            doneReg <= doneNext;
            dataReg <= dataNext;
            timeoutReg <= timeoutNext;
        end
    end

    assign pins = pinsReg;
    assign reqReady = readyReg;
    assign rspDone = doneReg;
    assign rspData = dataReg;
    assign rspTimeout = timeoutReg;

    // helper counts of strobe high time and write low time for the checks
    logic [7:0] weHighCnt, oeHighCnt, weLowCnt;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            weHighCnt <= 8'hff;
            oeHighCnt <= 8'hff;
            weLowCnt <= 8'h0;
        end else begin
            weLowCnt <= pinsReg.weN ? 8'h0 : (weLowCnt == 8'hff ? 8'hff : weLowCnt + 8'h1);
            weHighCnt <= !pinsReg.weN ? 8'h0 : (weHighCnt == 8'hff ? 8'hff : weHighCnt + 8'h1);
            oeHighCnt <= !pinsReg.oeN ? 8'h0 : (oeHighCnt == 8'hff ? 8'hff : oeHighCnt + 8'h1);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_oe_high_in_write;
        !pins.weN && !pins.ceN |-> pins.oeN;
    endproperty
    a_oe_high_in_write: assert property (p_oe_high_in_write) else $error("oe low in write");

    property p_write_gap;
        $fell(pins.weN) |-> weHighCnt >= WR_GAP_CYC;
    endproperty
    a_write_gap: assert property (p_write_gap) else $error("write high gap too short");

    property p_read_gap;
        $fell(pins.oeN) |-> oeHighCnt >= RD_GAP_CYC;
    endproperty
    a_read_gap: assert property (p_read_gap) else $error("read strobe gap too short");

    property p_poll_addr;
        !pins.oeN && pollReg |-> pins.addr == sectReg;
    endproperty
    a_poll_addr: assert property (p_poll_addr) else $error("poll address moved");

    property p_chip_final;
        !pins.weN && opReg == OP_CHIP_ERASE && stepReg == `DPS_LAST_ERASE
            |-> pins.addr == `DPS_UNLOCK_A1 && pins.dqOut == `DPS_D_CHIP && pins.dqOe;
    endproperty
    a_chip_final: assert property (p_chip_final) else $error("bad chip erase cycle");

    property p_sector_final;
        !pins.weN && opReg == OP_SECTOR_ERASE && stepReg == `DPS_LAST_ERASE
            |-> pins.addr == sectReg && pins.dqOut == `DPS_D_SECTOR;
    endproperty
    a_sector_final: assert property (p_sector_final) else $error("bad sector erase cycle");

    property p_write_pulse;
        $rose(pins.weN) |-> weLowCnt == WP_CYC;
    endproperty
    a_write_pulse: assert property (p_write_pulse) else $error("write pulse length wrong");

    property p_timeout_bound;
        pollReg |-> tmoReg <= ERASE_TIMEOUT_CYC + 32'h20;
    endproperty
    a_timeout_bound: assert property (p_timeout_bound) else $error("poll ran past timeout");

    property p_done_ready;
        doneReg |-> readyReg && stateReg == ST_IDLE && pins.ceN && !pins.dqOe;
    endproperty
    a_done_ready: assert property (p_done_ready) else $error("done without idle");

    c_chip_done: cover property (doneReg && opReg == OP_CHIP_ERASE && !timeoutReg);
    c_sector_done: cover property (doneReg && opReg == OP_SECTOR_ERASE && !timeoutReg);
    c_timeout: cover property (doneReg && timeoutReg);
    c_read_done: cover property (doneReg && opReg == OP_READ);

endmodule

// ==== test/dps_flash_model.sv ====
// bench model of the dual plane flash: array reads, erase status, id mode
// assumes host pins registered on clk; the data bus has no pull resistor
`timescale 1ns/1ns
module dps_flash_model
    import dps_pkg::*;
#(
    parameter logic [15:0] ID_WORD = 16'h005a // arbitrary value
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire dps_pins_t pins,
    input wire logic idEnter,
    input wire logic [31:0] busyCyc,
    input wire logic suspend,
    output logic [15:0] dqIn
);
    logic idMode, tgl, chipErase, planeB, pollSet, rdLast, wrLast;
    logic [2:0] wrCount;
    logic [15:0] lastDq, lastData;
    logic [18:0] pollAddr, lastAddr;
    logic [31:0] busyCnt, wrGap, rdGap, gap56, minRdGap, oeClash, addrMoves;
    wire rdOn = !pins.ceN && !pins.oeN;
    wire wrOn = !pins.ceN && !pins.weN;
    wire hit = busyCnt != 0 && (chipErase || ((pins.addr[18:16] != 3'h0) == planeB));
    wire inSect = pins.addr[18:12] == lastAddr[18:12]; // same 4K word sector as the erase

    // read data; a released bus shows the inverse of the last word
    always_comb begin
        logic [15:0] d;
        d = pins.addr[15:0] ^ 16'h3c5a;
        if (!rdOn) dqIn = ~lastDq;
        else if (idMode) dqIn = ID_WORD;
        else if (hit && !suspend) dqIn = {d[15:8], 1'b0, tgl, d[5:3], tgl, d[1:0]};
        else if (hit && inSect) dqIn = {d[15:8], 2'b11, d[5:3], tgl, d[1:0]};
        else dqIn = d;
    end

    // command decode, erase timer and host timing monitors
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            idMode <= 1'b0;
            {tgl, chipErase, planeB, pollSet, rdLast, wrLast} <= 6'h0;
            {wrCount, lastDq, lastData, pollAddr, lastAddr} <= '0;
            {busyCnt, wrGap, rdGap, gap56, oeClash, addrMoves} <= '0;
            minRdGap <= 32'hffffffff;
        end else begin
            rdLast <= rdOn;
            wrLast <= wrOn;
            wrGap <= pins.weN ? wrGap + 32'h1 : 32'h0;
            rdGap <= rdOn ? 32'h0 : rdGap + 32'h1;
            if (rdOn) lastDq <= dqIn;
            if (idEnter) idMode <= 1'b1;
            if (busyCnt != 0 && !suspend) busyCnt <= busyCnt - 32'h1;
            if (wrOn && !pins.oeN) oeClash <= oeClash + 32'h1;
            if (rdLast && !rdOn && busyCnt != 0) tgl <= !tgl;
            if (rdOn && !rdLast && busyCnt != 0) begin
                if (pollSet && pins.addr != pollAddr) addrMoves <= addrMoves + 32'h1;
                if (pollSet && rdGap < minRdGap) minRdGap <= rdGap;
                pollSet <= 1'b1;
                pollAddr <= pins.addr;
            end
            if (wrOn && !wrLast) begin
                if (pins.dqOut == 16'h00f0) begin
                    idMode <= 1'b0;
                    wrCount <= 3'h0;
                end else if (wrCount == 3'h5 && (pins.dqOut == 16'h0030
                        || (pins.dqOut == 16'h0010 && pins.addr == 19'h05555))) begin
                    busyCnt <= busyCyc;
                    chipErase <= pins.dqOut == 16'h0010;
                    planeB <= pins.addr[18:16] != 3'h0;
                    lastAddr <= pins.addr;
                    lastData <= pins.dqOut;
                    gap56 <= wrGap;
                    wrCount <= 3'h0;
                    pollSet <= 1'b0;
                end else begin
                    wrCount <= wrCount + 3'h1;
                end
            end
        end
    end
endmodule

// ==== test/dps_flash_host_test.sv ====
// self-checking bench for the dual plane flash host sequencer
// assumes the flash model of dps_flash_model.sv stands on the pins
`timescale 1ns/1ns
module dps_flash_host_test;
    import dps_pkg::*;
    logic clk, reset_n, reqValid, reqReady, rspDone, rspTimeout, idEnter, suspend;
    logic [15:0] rspData, dqIn, lfsr, e;
    logic [31:0] busyCyc, lat;
    int n_errors, checked;
    dps_req_t req;
    dps_pins_t pins;

    dps_flash_host #(.ERASE_TIMEOUT_CYC(32'h7d0)) dps_flash_host_inst (.clk(clk),
        .reset_n(reset_n), .reqValid(reqValid), .req(req), .reqReady(reqReady),
        .rspDone(rspDone), .rspData(rspData), .rspTimeout(rspTimeout), .pins(pins),
        .dqIn(dqIn));
    dps_flash_model dps_flash_model_inst (.clk(clk), .reset_n(reset_n), .pins(pins),
        .idEnter(idEnter), .busyCyc(busyCyc), .suspend(suspend), .dqIn(dqIn));

    function automatic logic [15:0] arr(input logic [18:0] a);
        return a[15:0] ^ 16'h3c5a;
    endfunction

    function automatic logic [15:0] step(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one request from a falling edge; lat counts cycles from take to done
    task automatic run(input dps_op_t op, input logic [18:0] a);
        int k;
        k = 0;
        while (reqReady !== 1'b1 && k < 100) begin
            @(negedge clk);
            k++;
        end
        reqValid = 1'b1;
        req = '{op: op, addr: a};
        @(posedge clk);
        @(negedge clk);
        reqValid = 1'b0;
        lat = 32'h1;
        while (rspDone !== 1'b1 && lat < 32'h4000) begin
            @(negedge clk);
            lat++;
        end
    endtask

    task automatic rdChk(input logic [18:0] a);
        run(OP_READ, a);
        chk("read latency", 32'h1c, lat);
        chk("read data", arr(a), rspData);
    endtask

    task automatic eraseChk(input logic [18:0] a, input logic [15:0] d);
        chk("erase address", a, dps_flash_model_inst.lastAddr);
        chk("erase data", d, dps_flash_model_inst.lastData);
        chk("gap before last cycle", 1, dps_flash_model_inst.gap56 >= 15);
        chk("timeout flag", 0, rspTimeout);
        chk("busy span", 1, lat > 32'h82 + busyCyc);
        chk("final status word", arr(dps_flash_model_inst.pollAddr), rspData);
    endtask

    task automatic results();
        $display("checked %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // watchdog well beyond the expected run length
    initial begin
        #400000;
        n_errors++;
        results();
    end

    initial begin
        reset_n = 1'b0;
        reqValid = 1'b0;
        req = '0;
        idEnter = 1'b0;
        suspend = 1'b0;
        busyCyc = 32'h0;
        lfsr = 16'h8fb2;
        repeat (10) @(negedge clk);
        chk("ready at reset", 1, reqReady);
        chk("strobes at reset", 3'h7, {pins.ceN, pins.oeN, pins.weN});
        chk("bus drive at reset", 0, pins.dqOe);
        reset_n = 1'b1;
        // random reads back to back, plane boundary first
        for (int i = 0; i < 14; i++) begin
            lfsr = step(lfsr);
            rdChk(i < 3 ? 19'h0ffff + 19'(i) : {lfsr[2:0], lfsr});
        end
        // chip erase, then sector erases in both planes
        busyCyc = 32'h190;
        run(OP_CHIP_ERASE, 19'h01234);
        eraseChk(19'h05555, 16'h0010);
        lfsr = step(lfsr);
        run(OP_SECTOR_ERASE, {3'h4, lfsr});
        eraseChk({3'h4, lfsr}, 16'h0030);
        run(OP_SECTOR_ERASE, 19'h08000);
        eraseChk(19'h08000, 16'h0030);
        // erase outlives the host limit; read both planes while busy
        busyCyc = 32'h1388;
        run(OP_SECTOR_ERASE, 19'h20000);
        chk("timeout flag", 1, rspTimeout);
        chk("poll address moves", 0, dps_flash_model_inst.addrMoves);
        run(OP_READ, 19'h00100);
        chk("other plane data", arr(19'h00100), rspData);
        e = arr(19'h20100);
        run(OP_READ, 19'h20100);
        chk("erasing plane status", {e[15:8], 1'b0}, rspData[15:7]);
        // suspended erase: erasing sector shows status, other sectors data
        suspend = 1'b1;
        run(OP_READ, 19'h20040);
        e = rspData;
        chk("suspended sector status", 2'h3, rspData[7:6]);
        run(OP_READ, 19'h20040);
        chk("suspended sector toggle", !e[2], rspData[2]);
        rdChk(19'h30100);
        suspend = 1'b0;
        while (dps_flash_model_inst.busyCnt != 0) @(negedge clk);
        // id mode left by both exit forms and by a power cycle
        for (int i = 0; i < 3; i++) begin
            @(negedge clk);
            idEnter = 1'b1;
            @(negedge clk);
            idEnter = 1'b0;
            run(OP_READ, 19'h00000);
            chk("id word", 16'h005a, rspData);
            if (i == 2) begin
                reset_n = 1'b0;
                @(negedge clk);
                reset_n = 1'b1;
            end else begin
                run(i ? OP_ID_EXIT_SHORT : OP_ID_EXIT_LONG, 19'h00000);
                chk("exit latency", i ? 32'h1b : 32'h4f, lat);
            end
            rdChk(19'h00000);
        end
        chk("oe low during write", 0, dps_flash_model_inst.oeClash);
        chk("read high gap", 1, dps_flash_model_inst.minRdGap >= 15);
        results();
    end
endmodule
